/* File: rtl/lfsr_step.sv */
// Galois LFSR register with step enable and programmable repeat length
`timescale 1ns/1ns
`include "precharge_clock_map.svh"
module lfsr_step #(
    parameter int          WIDTH = 8,
    parameter logic [15:0] TAPS  = 16'h00b8,
    parameter logic [15:0] SEED  = 16'h0001
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             step,
    input  wire logic             restart,
    output logic                  out_bit
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (WIDTH < 2 || WIDTH > 16) begin : g_bad_width
        $error("lfsr_step WIDTH must be 2..16");
    end

    logic [WIDTH-1:0] state_q;    // Shift register
    logic [WIDTH-1:0] state_d;    // Next shift value
    logic             out_bit_d;  // Next output bit

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Restart reloads the seed so the sequence period can be cut short
    always_comb begin
        state_d   = state_q;
        out_bit_d = out_bit;
        if (restart) begin
            state_d = SEED[WIDTH-1:0];
        end else if (step) begin
            state_d   = (state_q >> 1) ^ (state_q[0] ? TAPS[WIDTH-1:0] : '0);
            out_bit_d = state_q[0];
        end
    end

    // Register only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= SEED[WIDTH-1:0];
            out_bit <= 1'b0;
        end else begin
            state_q <= state_d;
            out_bit <= out_bit_d;
        end
    end
endmodule : lfsr_step

/* File: rtl/precharge_clock.sv */
// Spread-spectrum precharge switch clock generator, top level
`timescale 1ns/1ns
`include "precharge_clock_map.svh"
module precharge_clock
    import precharge_clock_pkg::*;
#(
    parameter int COLUMN_DIV_BITS = 8
) (
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    input  wire precharge_clock_pkg::source_sel_t source_sel,
    input  wire logic [`PRESCALER_BITS-1:0]    prescaler_period_value,
    input  wire logic [15:0]                   wide_period,
    input  wire precharge_clock_pkg::resolution_t resolution,
    input  wire logic [COLUMN_DIV_BITS-1:0]    column_clock_divider,
    output logic                               charge_phase,
    output logic                               transfer_phase,
    output logic                               sample_done
);
    import precharge_clock_pkg::*;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (COLUMN_DIV_BITS < 1 || COLUMN_DIV_BITS > 16) begin : g_bad_div
        $error("precharge_clock COLUMN_DIV_BITS must be 1..16");
    end

    // Sample length of the narrow configurations in column intervals
    function automatic logic [10:0] sample_len(input resolution_t r);
        case (r)
            RES_8:   sample_len = `SAMPLE_LEN_8BIT;
            RES_10:  sample_len = `SAMPLE_LEN_10BIT;
            RES_12:  sample_len = `SAMPLE_LEN_12BIT;
            default: sample_len = `SAMPLE_LEN_8BIT;
        endcase
    endfunction : sample_len

    // ------------------------------------------------------------
    // Configuration capture
    // ------------------------------------------------------------
    // Source is a configuration choice: taken once at reset release only
    source_sel_t cfg_q;             // Latched source
    source_sel_t cfg_d;             // Next latched source
    logic        cfg_valid_q;       // Latched since reset
    logic        cfg_valid_d;       // Next latched flag

    always_comb begin
        cfg_d       = cfg_q;
        cfg_valid_d = 1'b1;
        if (!cfg_valid_q) begin
            cfg_d = source_sel;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg_q       <= SRC_WIDE;
            cfg_valid_q <= 1'b0;
        end else begin
            cfg_q       <= cfg_d;
            cfg_valid_q <= cfg_valid_d;
        end
    end

    // ------------------------------------------------------------
    // Prescaler and step strobes
    // ------------------------------------------------------------
    logic [`PRESCALER_BITS-1:0] pres_q;      // Prescaler down count
    logic [`PRESCALER_BITS-1:0] pres_d;
    logic [15:0]                wide_cnt_q;  // Position in wide sequence
    logic [15:0]                wide_cnt_d;
    logic                       step_wide;   // Wide generator step
    logic                       step_narrow; // Narrow generator step
    logic                       wide_restart;

    // Software is expected to write 2^n-1 so samples hold whole periods
    always_comb begin
        pres_d = pres_q - 1'b1;
        if (pres_q == '0) begin
            pres_d = prescaler_period_value;
        end
    end

    // Steps depend only on the latched source and its latched flag, and in prescaled mode on the prescaler reaching zero
    always_comb begin
        step_wide    = cfg_valid_q && (cfg_q == SRC_WIDE);
        step_narrow  = 1'b0;
        case (cfg_q)
            SRC_NARROW:    step_narrow = cfg_valid_q;
            SRC_PRESCALED: step_narrow = cfg_valid_q && (pres_q == '0);
            default:       step_narrow = 1'b0;
        endcase
        wide_restart = step_wide && (wide_cnt_q >= wide_period);
        wide_cnt_d   = wide_cnt_q;
        if (wide_restart) begin
            wide_cnt_d = '0;
        end else if (step_wide) begin
            wide_cnt_d = wide_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pres_q     <= `PRESCALER_DEFAULT;
            wide_cnt_q <= '0;
        end else begin
            pres_q     <= pres_d;
            wide_cnt_q <= wide_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Generators
    // ------------------------------------------------------------
    logic wide_bit;    // Wide sequence output
    logic narrow_bit;  // Narrow sequence output

    lfsr_step #(
        .WIDTH (`WIDE_PRS_BITS),
        .TAPS  (`WIDE_PRS_TAPS),
        .SEED  (`WIDE_PRS_SEED)
    ) u_wide_pseudo_random_source (
        .core_clk (core_clk),
        .rst      (rst),
        .step     (step_wide),
        .restart  (wide_restart),
        .out_bit  (wide_bit)
    );

    lfsr_step #(
        .WIDTH (`NARROW_PRS_BITS),
        .TAPS  ({8'h00, `NARROW_PRS_TAPS}),
        .SEED  ({8'h00, `NARROW_PRS_SEED})
    ) u_narrow_pseudo_random_source (
        .core_clk (core_clk),
        .rst      (rst),
        .step     (step_narrow),
        .restart  (1'b0),
        .out_bit  (narrow_bit)
    );

    // ------------------------------------------------------------
    // Non-overlapping phase generation
    // ------------------------------------------------------------
    // A change of the selected bit passes through one dead cycle with
    // both switches open, so supply and modulator never short together.
    phase_state_t ph_q;
    phase_state_t ph_d;
    logic         sel_bit;
    logic         charge_d;
    logic         transfer_d;

    always_comb begin
        sel_bit = (cfg_q == SRC_WIDE) ? wide_bit : narrow_bit;
        ph_d    = ph_q;
        case (ph_q)
            PH_IDLE:     ph_d = sel_bit ? PH_CHARGE : PH_TRANSFER;
            PH_CHARGE:   ph_d = sel_bit ? PH_CHARGE : PH_IDLE;
            PH_TRANSFER: ph_d = sel_bit ? PH_IDLE : PH_TRANSFER;
            default:     ph_d = PH_IDLE;
        endcase
        if (!cfg_valid_q) begin
            ph_d = PH_IDLE;
        end
        charge_d   = (ph_d == PH_CHARGE);
        transfer_d = (ph_d == PH_TRANSFER);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ph_q           <= PH_IDLE;
            charge_phase   <= 1'b0;
            transfer_phase <= 1'b0;
        end else begin
            ph_q           <= ph_d;
            charge_phase   <= charge_d;
            transfer_phase <= transfer_d;
        end
    end

    // ------------------------------------------------------------
    // Column clock and sample timer
    // ------------------------------------------------------------
    // Column interval is the divider value plus one oscillator cycles
    logic [COLUMN_DIV_BITS-1:0] col_q;
    logic [COLUMN_DIV_BITS-1:0] col_d;
    logic [10:0]                samp_q;
    logic [10:0]                samp_d;
    logic                       done_d;

    always_comb begin
        col_d  = col_q + 1'b1;
        samp_d = samp_q;
        done_d = 1'b0;
        if (col_q >= column_clock_divider) begin
            col_d  = '0;
            samp_d = samp_q + 11'd1;
            if (samp_q + 11'd1 >= sample_len(resolution)) begin
                samp_d = '0;
                done_d = (cfg_q != SRC_WIDE) && cfg_valid_q;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            col_q       <= '0;
            samp_q      <= '0;
            sample_done <= 1'b0;
        end else begin
            col_q       <= col_d;
            samp_q      <= samp_d;
            sample_done <= done_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_phase_no_overlap: assert property (
        @(posedge core_clk) disable iff (rst) !(charge_phase && transfer_phase))
        else $error("Charge and transfer phases overlap");

    chk_phase_dead_gap: assert property (
        @(posedge core_clk) disable iff (rst) $fell(charge_phase) |-> !transfer_phase)
        else $error("No dead cycle between phases");

    chk_prescale_reload: assert property (
        @(posedge core_clk) disable iff (rst)
        (pres_q == '0) |=> (pres_q == $past(prescaler_period_value)))
        else $error("Prescaler did not reload period");

    chk_narrow_direct: assert property (
        @(posedge core_clk) disable iff (rst)
        (cfg_valid_q && cfg_q == SRC_NARROW) |-> step_narrow && !step_wide)
        else $error("Narrow source not stepped every cycle");

    chk_prescale_step: assert property (
        @(posedge core_clk) disable iff (rst)
        (cfg_q == SRC_PRESCALED && step_narrow) |-> pres_q == '0)
        else $error("Prescaled step off terminal count");

    chk_wide_direct: assert property (
        @(posedge core_clk) disable iff (rst)
        (cfg_valid_q && cfg_q == SRC_WIDE) |-> step_wide && !step_narrow)
        else $error("Wide source not stepped every cycle");

    chk_wide_period: assert property (
        @(posedge core_clk) disable iff (rst) wide_cnt_q <= wide_period || wide_restart
        || !step_wide)
        else $error("Wide sequence ran past its period");

    chk_config_fixed: assert property (
        @(posedge core_clk) disable iff (rst) cfg_valid_q |=> $stable(cfg_q))
        else $error("Source changed after configuration");
endmodule : precharge_clock

/* File: rtl/precharge_clock_map.svh */
// Constants for the spread-spectrum precharge clock block
`ifndef PRECHARGE_CLOCK_MAP_SVH
`define PRECHARGE_CLOCK_MAP_SVH
// ------------------------------------------------------------
// Generator widths
// ------------------------------------------------------------
`define WIDE_PRS_BITS        16
`define NARROW_PRS_BITS      8
`define PRESCALER_BITS       8
// ------------------------------------------------------------
// Reset, seed and tap values
// ------------------------------------------------------------
`define WIDE_PRS_SEED        16'h0001
`define NARROW_PRS_SEED      8'h01
`define WIDE_PRS_TAPS        16'hb400
`define NARROW_PRS_TAPS      8'hb8
`define WIDE_PERIOD_DEFAULT  16'hffff
`define PRESCALER_DEFAULT    8'h00
// ------------------------------------------------------------
// Decimator sample lengths in column clock intervals
// ------------------------------------------------------------
`define SAMPLE_LEN_8BIT      11'd128
`define SAMPLE_LEN_10BIT     11'd256
`define SAMPLE_LEN_12BIT     11'd1024
`endif

/* File: rtl/precharge_clock_pkg.sv */
// Types for the spread-spectrum precharge clock block
package precharge_clock_pkg;
    // Clock source selection
    typedef enum logic [1:0] {
        SRC_WIDE      = 2'h0,
        SRC_NARROW    = 2'h1,
        SRC_PRESCALED = 2'h2
    } source_sel_t;
    // Sample resolution in narrow configurations
    typedef enum logic [1:0] {
        RES_8  = 2'h0,
        RES_10 = 2'h1,
        RES_12 = 2'h2
    } resolution_t;
    // Switch phase state, one-hot
    typedef enum logic [2:0] {
        PH_IDLE     = 3'b001,
        PH_CHARGE   = 3'b010,
        PH_TRANSFER = 3'b100
    } phase_state_t;
endpackage : precharge_clock_pkg

/* File: sim/switch_model.sv */
// Behavioural model of the sensing switches and modulator
`timescale 1ns/1ns
module switch_model (
    input  wire logic core_clk,
    input  wire logic clear,
    input  wire logic charge_phase,
    input  wire logic transfer_phase,
    output int        transfers,
    output logic      short_seen
);
    // ----------------------------------------
    // Sensing capacitor charge bookkeeping
    // ----------------------------------------
    logic charged_q; // Capacitor holds supply charge

    // Counts charge packets dumped into the modulator capacitor
    always_ff @(posedge core_clk) begin
        if (clear) begin
            charged_q  <= 1'b0;
            transfers  <= 0;
            short_seen <= 1'b0;
        end else begin
            // Supply switch closed: capacitor charges fully
            if (charge_phase) begin
                charged_q <= 1'b1;
            end else if (transfer_phase && charged_q) begin
                charged_q <= 1'b0;
                transfers <= transfers + 1;
            end
            // Both closed would short supply into the modulator
            if (charge_phase && transfer_phase) begin
                short_seen <= 1'b1;
            end
        end
    end
endmodule : switch_model

/* File: sim/tb_spread_spectrum_precharge_clock.sv */
// Self-checking testbench for the precharge clock generator
`timescale 1ns/1ns
module tb_spread_spectrum_precharge_clock;
    import precharge_clock_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        core_clk;               // 250 MHz clock
    logic        rst;                    // Synchronous reset
    source_sel_t source_sel;             // Generator choice
    logic [7:0]  prescaler_period_value; // Prescaler reload
    logic [15:0] wide_period;            // Wide repeat length minus one
    resolution_t resolution;             // Sample length choice
    logic [7:0]  column_clock_divider;   // Column interval minus one
    logic        charge_phase;
    logic        transfer_phase;
    logic        sample_done;
    logic        model_clear;            // Clears partner counts
    int          transfers;
    logic        short_seen;
    int          n_errors;
    int          checks;
    int          i;
    logic [7:0]  rnd;                    // Bench random state
    logic [2:0]  smp[$];                 // Per-cycle output record
    int          runs[$];                // Modelled narrow bit run lengths

    precharge_clock #(.COLUMN_DIV_BITS(8)) precharge_clock_inst (
        .core_clk(core_clk), .rst(rst), .source_sel(source_sel),
        .prescaler_period_value(prescaler_period_value), .wide_period(wide_period),
        .resolution(resolution), .column_clock_divider(column_clock_divider),
        .charge_phase(charge_phase), .transfer_phase(transfer_phase),
        .sample_done(sample_done));
    switch_model switch_model_inst (
        .core_clk(core_clk), .clear(model_clear), .charge_phase(charge_phase),
        .transfer_phase(transfer_phase), .transfers(transfers), .short_seen(short_seen));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        lfsr_next = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next

    function automatic int slen(input resolution_t r);
        slen = (r == RES_8) ? 128 : (r == RES_10) ? 256 : 1024;
    endfunction : slen

    task automatic check(input bit ok, input string msg);
        checks++;
        if (!ok) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check

    // Run lengths of the narrow generator bit, seed one, shifted-out LSB
    task automatic build_runs(input int n);
        logic [7:0] s;
        logic       b;
        logic       prev;
        int         len;
        s = 8'h01;
        prev = 1'b1;
        len = 0;
        runs = {};
        repeat (n) begin
            b = s[0];
            s = s >> 1;
            if (b) s = s ^ 8'hb8;
            if (b === prev) len++;
            else begin
                runs.push_back(len);
                len = 1;
            end
            prev = b;
        end
    endtask : build_runs

    task automatic close_out;
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    // Reset, capture config, record n cycles, then judge the record
    task automatic run_case(input source_sel_t src, input logic [7:0] pv,
                            input logic [15:0] wp, input resolution_t res,
                            input logic [7:0] dv, input int n);
        int fl[$];
        int dn[$];
        int per;
        int k;
        rst = 1'b1;
        model_clear = 1'b1;
        source_sel = src;
        prescaler_period_value = pv;
        wide_period = wp;
        resolution = res;
        column_clock_divider = dv;
        // Outputs stay low under reset and one edge after; phases may move from the second
        repeat (2) begin
            @(negedge core_clk);
            check({charge_phase, transfer_phase, sample_done} === 3'b000, "reset");
            rst = 1'b0;
            model_clear = 1'b0;
        end
        // Late selection change must be ignored until the next reset
        source_sel = (src == SRC_WIDE) ? SRC_NARROW : SRC_WIDE;
        smp = {};
        repeat (n) begin
            @(negedge core_clk);
            smp.push_back({charge_phase, transfer_phase, sample_done});
        end
        per = (src == SRC_WIDE) ? int'(wp) + 1 : 255;
        for (k = 0; k < n - 1; k++) begin
            if (smp[k][2:1] != 2'b00 && smp[k+1][2:1] == 2'b00) fl.push_back(k);
            if (smp[k][0] === 1'b1) dn.push_back(k);
            check(smp[k][2:1] !== 2'b11, "both switches closed");
            if (smp[k][2:1] != 2'b00 && smp[k+1][2:1] != 2'b00)
                check(smp[k][2:1] === smp[k+1][2:1], "no dead gap");
            if (src != SRC_PRESCALED && k >= 40 && k + per < n)
                check(smp[k][2:1] === smp[k+per][2:1], "repeat length");
        end
        check(fl.size() >= 4, "phases idle");
        if (src == SRC_WIDE) check(dn.size() == 0, "sample pulse in wide");
        else check(dn.size() >= 2, "too few sample pulses");
        for (k = 1; k < dn.size(); k++)
            check(dn[k] - dn[k-1] == (int'(dv) + 1) * slen(res), "sample spacing");
        if (src == SRC_PRESCALED) begin
            build_runs(n);
            // Fall k-1 opens bit run k-1 and fall k closes it
            for (k = 1; k < fl.size() && k <= runs.size(); k++) begin
                check(fl[k] - fl[k-1] == (int'(pv) + 1) * runs[k-1], "step spacing");
                if (fl[k] + 2 < n)
                    check(smp[fl[k]+2][2:1] !== 2'b00, "gap too long");
            end
        end
        // Partner flag is cleared by the next reset, so judge it per run
        check(short_seen === 1'b0, "supply shorted in run");
    endtask : run_case

    // ----------------------------------------
    // Clock, watchdog and scenarios
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Longest run is near 9.5k cycles, so this only fires on a hang
    initial begin
        #(4 * 80000);
        n_errors++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        model_clear = 1'b1;
        source_sel = SRC_WIDE;
        prescaler_period_value = 8'h00;
        wide_period = 16'hffff;
        resolution = RES_8;
        column_clock_divider = 8'h00;
        n_errors = 0;
        checks = 0;
        rnd = 8'h3e;
        repeat (12) @(negedge core_clk);
        run_case(SRC_WIDE, 8'h00, 16'h001f, RES_8, 8'h00, 300);
        run_case(SRC_WIDE, 8'h07, 16'h0063, RES_12, 8'h05, 400);
        for (i = 0; i < 3; i++) begin
            rnd = lfsr_next(rnd);
            run_case(SRC_NARROW, rnd, 16'hffff, resolution_t'(i), {6'h00, rnd[1:0]},
                     3 * (int'(rnd[1:0]) + 1) * slen(resolution_t'(i)) + 300);
        end
        // Prescaler periods 1, 3 and 7: powers of two minus one
        for (i = 0; i < 3; i++) begin
            rnd = lfsr_next(rnd);
            run_case(SRC_PRESCALED, (8'h02 << i) - 8'h01, {rnd, rnd}, RES_8,
                     {7'h00, rnd[0]}, 1800);
        end
        check(transfers > 10, "no charge transfers");
        check(short_seen === 1'b0, "supply shorted");
        close_out();
    end
endmodule : tb_spread_spectrum_precharge_clock
